// *** supply_supervisor_watchdog.sv ***
`timescale 1ns/1ps

module supply_supervisor_watchdog #(
    parameter bit RESET_ACTIVE_HIGH = 1'b0,
    parameter int WD_CYC0 = supervisor_pkg::WD_PERIOD0_CYC,
    parameter int WD_CYC1 = supervisor_pkg::WD_PERIOD1_CYC,
    parameter int WD_CYC2 = supervisor_pkg::WD_PERIOD2_CYC,
    parameter int HOLD_CYC0 = supervisor_pkg::HOLD0_CYC,
    parameter int HOLD_CYC1 = supervisor_pkg::HOLD1_CYC,
    parameter int HOLD_CYC2 = supervisor_pkg::HOLD2_CYC,
    parameter int HOLD_CYC3 = supervisor_pkg::HOLD3_CYC
) (
    // System clock and power-on reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Serial bus, sampled on the link clock
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic write_protect_in,
    // Supervisor pins
    input wire logic manual_reset_in_n,
    input wire supervisor_pkg::supply_flags_t flags_in,
    output logic sys_reset_out,
    output logic primary_fail_n,
    output logic second_supply_fail_out_n,
    output logic switched_supply_out,
    output logic backup_active_out,
    output logic watchdog_fault_out_n,
    // Nonvolatile control byte store
    input wire supervisor_pkg::ctrl_byte_t nv_ctrl_in,
    output supervisor_pkg::ctrl_byte_t nv_ctrl_out,
    output logic nv_write_out
);

    localparam bit RST_ON = RESET_ACTIVE_HIGH;

    logic rst_meta_q;
    logic rst_sys_n;
    logic lrst_meta_q;
    logic rst_link_n;

    // Reset release, one copy per domain
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            rst_sys_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sys_n <= rst_meta_q;
        end
    end

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            lrst_meta_q <= 1'b0;
            rst_link_n <= 1'b0;
        end else begin
            lrst_meta_q <= 1'b1;
            rst_link_n <= lrst_meta_q;
        end
    end

    // ---------------- Link domain ----------------
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic backup_ls;
    logic scl_p_q;
    logic sda_p_q;
    logic backup_q;

    sync2 #(.WIDTH(4)) u_link_sync (
        .clk(link_clk),
        .rst_n(rst_link_n),
        .d({scl_in, sda_in, write_protect_in, backup_q}),
        .q({scl_s, sda_s, wp_s, backup_ls})
    );

    always_ff @(posedge link_clk or negedge rst_link_n) begin
        if (!rst_link_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;

    // Receiver runs regardless of mode so restarts are never missed
    assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;

    supervisor_pkg::restart_state_t wst_q;
    logic restart_tog_q;

    // Start, clock low, clock high, stop
    always_ff @(posedge link_clk or negedge rst_link_n) begin
        if (!rst_link_n) begin
            wst_q <= supervisor_pkg::W_IDLE;
            restart_tog_q <= 1'b0;
        end else if (start_ev) begin
            wst_q <= supervisor_pkg::W_START;
        end else if (stop_ev) begin
            if (wst_q == supervisor_pkg::W_HIGH) begin
                restart_tog_q <= ~restart_tog_q;
            end
            wst_q <= supervisor_pkg::W_IDLE;
        end else begin
            unique case (wst_q)
                supervisor_pkg::W_START: begin
                    if (scl_fall) begin
                        wst_q <= supervisor_pkg::W_LOW;
                    end
                end
                supervisor_pkg::W_LOW: begin
                    if (scl_rise) begin
                        wst_q <= supervisor_pkg::W_HIGH;
                    end
                end
                supervisor_pkg::W_IDLE, supervisor_pkg::W_HIGH: begin
                end
            endcase
        end
    end

    supervisor_pkg::slave_state_t sst_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [1:0] byte_idx_q;
    logic [7:0] data_q;
    logic have_data_q;
    logic wr_tog_q;
    logic [7:0] wr_byte_q;
    logic ack_ok;

    // Control slave byte, write only; nothing answered in backup
    assign ack_ok = ~backup_ls & (byte_idx_q != 2'h0 |
        (shift_q[7:4] == supervisor_pkg::CTRL_PREAMBLE & ~shift_q[0]));

    always_ff @(posedge link_clk or negedge rst_link_n) begin
        if (!rst_link_n) begin
            sst_q <= supervisor_pkg::S_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            byte_idx_q <= 2'h0;
            data_q <= 8'h00;
            have_data_q <= 1'b0;
            wr_tog_q <= 1'b0;
            wr_byte_q <= 8'h00;
            sda_oe <= 1'b0;
        end else if (start_ev) begin
            sst_q <= supervisor_pkg::S_BITS;
            bit_cnt_q <= 4'h0;
            byte_idx_q <= 2'h0;
            have_data_q <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_ev) begin
            sst_q <= supervisor_pkg::S_IDLE;
            sda_oe <= 1'b0;
            have_data_q <= 1'b0;
            if (have_data_q && !wp_s) begin
                wr_tog_q <= ~wr_tog_q;
                wr_byte_q <= data_q;
            end
        end else begin
            unique case (sst_q)
                supervisor_pkg::S_BITS: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall &&
                        bit_cnt_q == supervisor_pkg::BITS_PER_BYTE) begin
                        bit_cnt_q <= 4'h0;
                        if (ack_ok) begin
                            sst_q <= supervisor_pkg::S_ACK;
                            sda_oe <= 1'b1;
                            if (byte_idx_q == supervisor_pkg::DATA_BYTE_IDX)
                            begin
                                data_q <= shift_q;
                                have_data_q <= 1'b1;
                            end
                        end else begin
                            sst_q <= supervisor_pkg::S_SKIP;
                        end
                    end
                end
                supervisor_pkg::S_ACK: begin
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        byte_idx_q <= byte_idx_q + 2'h1;
                        if (byte_idx_q == supervisor_pkg::DATA_BYTE_IDX) begin
                            sst_q <= supervisor_pkg::S_SKIP;
                        end else begin
                            sst_q <= supervisor_pkg::S_BITS;
                        end
                    end
                end
                supervisor_pkg::S_IDLE, supervisor_pkg::S_SKIP: begin
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge rst_link_n) begin
        if (!rst_link_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ---------------- System domain ----------------
    logic mr_n_s;
    logic prim_low_s;
    logic sec_low_s;
    logic below_s;
    logic above_s;
    logic restart_s;
    logic wr_s;
    logic restart_p_q;
    logic wr_p_q;

    sync2 #(.WIDTH(7)) u_sys_sync (
        .clk(clk_sys),
        .rst_n(rst_sys_n),
        .d({manual_reset_in_n, flags_in, restart_tog_q, wr_tog_q}),
        .q({mr_n_s, prim_low_s, sec_low_s, below_s, above_s,
            restart_s, wr_s})
    );

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            restart_p_q <= 1'b0;
            wr_p_q <= 1'b0;
        end else begin
            restart_p_q <= restart_s;
            wr_p_q <= wr_s;
        end
    end

    logic restart_ev;
    logic wr_ev;

    assign restart_ev = restart_s ^ restart_p_q;
    assign wr_ev = wr_s ^ wr_p_q;

    supervisor_pkg::ctrl_byte_t ctrl_q;
    logic loaded_q;

    // Stored byte reloaded after each power-up; writes go back out
    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            ctrl_q <= supervisor_pkg::CTRL_RST;
            loaded_q <= 1'b0;
            nv_ctrl_out <= supervisor_pkg::CTRL_RST;
            nv_write_out <= 1'b0;
        end else begin
            nv_write_out <= 1'b0;
            if (!loaded_q) begin
                ctrl_q <= nv_ctrl_in;
                loaded_q <= 1'b1;
            end else if (wr_ev) begin
                ctrl_q <= wr_byte_q;
                nv_ctrl_out <= wr_byte_q;
                nv_write_out <= 1'b1;
            end
        end
    end

    logic [31:0] hold_cyc;

    always_comb begin
        unique case ({ctrl_q.pup1, ctrl_q.pup0})
            2'h0: hold_cyc = 32'(HOLD_CYC0);
            2'h1: hold_cyc = 32'(HOLD_CYC1);
            2'h2: hold_cyc = 32'(HOLD_CYC2);
            2'h3: hold_cyc = 32'(HOLD_CYC3);
        endcase
    end

    // Entry 0 drives system reset, entry 1 the primary fail flag
    logic [1:0] cause;
    logic [1:0] active_q;

    assign cause[0] = prim_low_s | ~mr_n_s;
    assign cause[1] = prim_low_s;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_hold
            logic [31:0] cnt_q;

            always_ff @(posedge clk_sys or negedge rst_sys_n) begin
                if (!rst_sys_n) begin
                    cnt_q <= 32'h0;
                    active_q[gi] <= 1'b1;
                end else if (cause[gi] || !loaded_q) begin
                    cnt_q <= 32'h0;
                    active_q[gi] <= 1'b1;
                end else if (cnt_q >= hold_cyc - 32'h1) begin
                    active_q[gi] <= 1'b0;
                end else begin
                    cnt_q <= cnt_q + 32'h1;
                end
            end
        end
    endgenerate

    // Reset pin is driven active whenever the power-on reset is held
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sys_reset_out <= RST_ON;
            primary_fail_n <= 1'b0;
        end else if (!rst_sys_n) begin
            sys_reset_out <= RST_ON;
            primary_fail_n <= 1'b0;
        end else begin
            sys_reset_out <= active_q[0] ? RST_ON : ~RST_ON;
            primary_fail_n <= ~active_q[1];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            second_supply_fail_out_n <= 1'b1;
        end else begin
            second_supply_fail_out_n <= ~sec_low_s;
        end
    end

    // Comparators give vcc below backup_supply-0.03V and above backup_supply+0.03V
    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            backup_q <= 1'b0;
        end else if (prim_low_s && below_s) begin
            backup_q <= 1'b1;
        end else if (!prim_low_s || above_s) begin
            backup_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            switched_supply_out <= 1'b0;
            backup_active_out <= 1'b0;
        end else begin
            switched_supply_out <= backup_q;
            backup_active_out <= backup_q;
        end
    end

    logic [31:0] wd_cyc;

    always_comb begin
        unique case (ctrl_q.wd)
            2'h0: wd_cyc = 32'(WD_CYC0);
            2'h1: wd_cyc = 32'(WD_CYC1);
            2'h2: wd_cyc = 32'(WD_CYC2);
            2'h3: wd_cyc = 32'h0;
        endcase
    end

    logic [31:0] wd_cnt_q;

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            wd_cnt_q <= 32'h0;
            watchdog_fault_out_n <= 1'b1;
        end else if (restart_ev || active_q[0] ||
            ctrl_q.wd == supervisor_pkg::WD_OFF) begin
            wd_cnt_q <= 32'h0;
            watchdog_fault_out_n <= 1'b1;
        end else if (wd_cnt_q >= wd_cyc - 32'h1) begin
            watchdog_fault_out_n <= 1'b0;
        end else begin
            wd_cnt_q <= wd_cnt_q + 32'h1;
        end
    end

endmodule : supply_supervisor_watchdog

// *** supervisor_pkg.sv ***
package supervisor_pkg;

    // Internal timebase
    localparam int CLK_MHZ = 100;

    // Watchdog periods, microseconds; code 3 turns the watchdog off
    localparam int WD_PERIOD0_US = 1000;
    localparam int WD_PERIOD1_US = 4000;
    localparam int WD_PERIOD2_US = 16000;
    localparam int WD_PERIOD0_CYC = WD_PERIOD0_US * CLK_MHZ;
    localparam int WD_PERIOD1_CYC = WD_PERIOD1_US * CLK_MHZ;
    localparam int WD_PERIOD2_CYC = WD_PERIOD2_US * CLK_MHZ;
    localparam logic [1:0] WD_OFF = 2'h3;

    // Reset hold times, microseconds
    localparam int HOLD0_US = 500;
    localparam int HOLD1_US = 1000;
    localparam int HOLD2_US = 2000;
    localparam int HOLD3_US = 4000;
    localparam int HOLD0_CYC = HOLD0_US * CLK_MHZ;
    localparam int HOLD1_CYC = HOLD1_US * CLK_MHZ;
    localparam int HOLD2_CYC = HOLD2_US * CLK_MHZ;
    localparam int HOLD3_CYC = HOLD3_US * CLK_MHZ;

    // Serial slave decode
    localparam logic [3:0] CTRL_PREAMBLE = 4'hb;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] DATA_BYTE_IDX = 2'h2;

    // Control byte layout, bit 7 down to bit 0
    typedef struct packed {
        logic pup1;
        logic [1:0] wd;
        logic [1:0] zero;
        logic rwel;
        logic wel;
        logic pup0;
    } ctrl_byte_t;

    localparam ctrl_byte_t CTRL_RST = 8'h00;

    // Comparator flags from the analog front end
    typedef struct packed {
        logic primary_low;
        logic second_low;
        logic below_batt;
        logic above_batt;
    } supply_flags_t;

    typedef enum logic [1:0] {
        S_IDLE,
        S_BITS,
        S_ACK,
        S_SKIP
    } slave_state_t;

    typedef enum logic [1:0] {
        W_IDLE,
        W_START,
        W_LOW,
        W_HIGH
    } restart_state_t;

endpackage : supervisor_pkg

// *** sync2.sv ***
`timescale 1ns/1ps

module sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule : sync2

// *** supervisor_props.sv ***
`timescale 1ns/1ps

module supervisor_props #(
    parameter bit RESET_ACTIVE_HIGH = 1'b0,
    parameter int WD_CYC0 = 200,
    parameter int HOLD_CYC0 = 50
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Inputs
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic write_protect_in,
    input wire logic manual_reset_in_n,
    input wire supervisor_pkg::supply_flags_t flags_in,
    // Outputs
    input wire logic sda_oe,
    input wire logic sys_reset_out,
    input wire logic primary_fail_n,
    input wire logic second_supply_fail_out_n,
    input wire logic switched_supply_out,
    input wire logic backup_active_out,
    input wire logic watchdog_fault_out_n,
    input wire logic nv_write_out
);
    localparam int WD_MIN = WD_CYC0 - 16;
    logic [15:0] held_q;
    logic [15:0] idle_q;
    logic act;
    assign act = (sys_reset_out == RESET_ACTIVE_HIGH);
    // Cycles since the last reset cause
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn || flags_in.primary_low || !manual_reset_in_n) begin
            held_q <= 16'h0000;
        end else if (held_q != 16'hffff) begin
            held_q <= held_q + 16'h0001;
        end
    end
    // Cycles since the last stop or active system reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            idle_q <= 16'h0000;
        end else if (act || (scl_in && $rose(sda_in))) begin
            idle_q <= 16'h0000;
        end else if (idle_q != 16'hffff) begin
            idle_q <= idle_q + 16'h0001;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    chk_second_set: assert property (
        flags_in.second_low [*8] |-> !second_supply_fail_out_n)
        else $error("second fail not set");
    chk_second_clear: assert property (
        !flags_in.second_low [*8] |-> second_supply_fail_out_n)
        else $error("second fail not cleared");
    chk_primary_reset: assert property (
        flags_in.primary_low [*8] |-> act && !primary_fail_n)
        else $error("low primary without reset");
    chk_manual_reset: assert property (
        !manual_reset_in_n [*8] |-> act)
        else $error("manual reset ignored");
    chk_release_hold: assert property (
        $changed(sys_reset_out) && !act |-> held_q >= HOLD_CYC0)
        else $error("reset released early");
    chk_wd_period: assert property (
        $fell(watchdog_fault_out_n) |-> idle_q >= WD_MIN)
        else $error("watchdog fault early");
    chk_backup_follow: assert property (
        (!flags_in.primary_low) [*8] |->
        !backup_active_out && backup_active_out == switched_supply_out)
        else $error("backup output mismatch");
    chk_backup_enter: assert property (
        (flags_in.primary_low && flags_in.below_batt) [*8]
        |-> switched_supply_out)
        else $error("backup not selected");
    chk_no_ack_backup: assert property (
        switched_supply_out [*8] |-> !sda_oe)
        else $error("ack while in backup");
    chk_store_pulse: assert property (
        nv_write_out |=> !nv_write_out)
        else $error("store pulse too long");
    chk_wp_block: assert property (
        write_protect_in [*8] |-> !nv_write_out)
        else $error("store while protected");
    cover property (flags_in.primary_low ##1 act);
    cover property (nv_write_out);
    cover property ($fell(watchdog_fault_out_n));
    cover property ($rose(switched_supply_out));
endmodule : supervisor_props

bind supply_supervisor_watchdog supervisor_props #(
    .RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH),
    .WD_CYC0(WD_CYC0),
    .HOLD_CYC0(HOLD_CYC0)
) supervisor_props_i (
    .clk_sys, .rstn, .scl_in, .sda_in, .write_protect_in,
    .manual_reset_in_n, .flags_in, .sda_oe, .sys_reset_out,
    .primary_fail_n, .second_supply_fail_out_n, .switched_supply_out,
    .backup_active_out, .watchdog_fault_out_n, .nv_write_out
);

// *** serial_host_model.sv ***
`timescale 1ns/1ps

module serial_host_model (
    // Link clock
    input wire logic link_clk,
    // Device pull on the data wire
    input wire logic sda_out,
    input wire logic sda_oe,
    // Wire levels
    output logic scl,
    output logic sda
);
    logic sda_drv;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Pulled up, low while either side pulls
    assign sda = sda_drv & ~(sda_oe & ~sda_out);
    task automatic gap(input int n);
        repeat (n) @(posedge link_clk);
    endtask : gap
    task automatic start_cond();
        gap(1);
        sda_drv <= 1'b0;
        gap(5);
        scl <= 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        gap(2);
        sda_drv <= 1'b0;
        gap(3);
        scl <= 1'b1;
        gap(5);
        sda_drv <= 1'b1;
        gap(5);
    endtask : stop_cond
    task automatic clock_bit(input logic b, output logic seen);
        gap(2);
        sda_drv <= b;
        gap(3);
        scl <= 1'b1;
        gap(5);
        seen = sda;
        scl <= 1'b0;
    endtask : clock_bit
    // Start, clock low, clock high, stop
    task automatic restart();
        start_cond();
        stop_cond();
    endtask : restart
    // Acks come back first byte in the top bit
    task automatic write_ctrl(input logic [7:0] slave, addr, data,
                              output logic [2:0] acks);
        logic [23:0] frame;
        logic s;
        frame = {slave, addr, data};
        start_cond();
        for (int i = 23; i >= 0; i--) begin
            clock_bit(frame[i], s);
            if (i % 8 == 0) begin
                clock_bit(1'b1, s);
                acks[i / 8] = !s;
            end
        end
        stop_cond();
    endtask : write_ctrl
endmodule : serial_host_model

// *** supply_supervisor_watchdog_bench.sv ***
`timescale 1ns/1ps

module supply_supervisor_watchdog_bench;
    localparam int WD0 = 300;
    localparam int H0 = 50;
    logic clk_sys = 1'b0;
    logic link_clk = 1'b0;
    logic rstn = 1'b0;
    logic write_protect_in = 1'b0;
    logic manual_reset_in_n = 1'b1;
    supervisor_pkg::supply_flags_t flags_in = 4'h1;
    supervisor_pkg::ctrl_byte_t nv_ctrl_in = 8'h00;
    supervisor_pkg::ctrl_byte_t nv_ctrl_out;
    logic scl_in, sda_in, sda_out, sda_oe, sys_reset_out, primary_fail_n;
    logic second_supply_fail_out_n, switched_supply_out, backup_active_out;
    logic watchdog_fault_out_n, nv_write_out;
    int fail_count = 0;
    int n_compared = 0;
    int hold;
    int n_store = 0;
    int base;
    logic [31:0] seed = 32'h5a40;
    logic [2:0] acks;
    logic [7:0] want;
    logic [7:0] d;
    always #5 clk_sys = ~clk_sys;
    // Store pulse lasts one cycle and ends before the host task returns
    always @(negedge clk_sys) begin
        if (nv_write_out === 1'b1) begin
            n_store <= n_store + 1;
        end
    end
    initial begin
        #2.3;
        forever #15 link_clk = ~link_clk;
    end
    supply_supervisor_watchdog #(
        .WD_CYC0(WD0), .WD_CYC1(3000), .WD_CYC2(6000),
        .HOLD_CYC0(H0), .HOLD_CYC1(100), .HOLD_CYC2(150), .HOLD_CYC3(200)
    ) supply_supervisor_watchdog_i (
        .clk_sys(clk_sys), .rstn(rstn), .link_clk(link_clk),
        .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe(sda_oe), .write_protect_in(write_protect_in),
        .manual_reset_in_n(manual_reset_in_n), .flags_in(flags_in),
        .sys_reset_out(sys_reset_out), .primary_fail_n(primary_fail_n),
        .second_supply_fail_out_n(second_supply_fail_out_n),
        .switched_supply_out(switched_supply_out),
        .backup_active_out(backup_active_out),
        .watchdog_fault_out_n(watchdog_fault_out_n),
        .nv_ctrl_in(nv_ctrl_in), .nv_ctrl_out(nv_ctrl_out),
        .nv_write_out(nv_write_out)
    );
    serial_host_model serial_host_model_i (
        .link_clk(link_clk), .sda_out(sda_out), .sda_oe(sda_oe),
        .scl(scl_in), .sda(sda_in)
    );
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [7:0] ctrl_of(input logic [1:0] pup);
        return {pup[1], 2'h0, 4'h0, pup[0]};
    endfunction : ctrl_of
    function automatic int hold_of(input logic [7:0] c);
        return H0 * (1 + {c[7], c[0]});
    endfunction : hold_of
    task automatic check_bit(input string what, input logic exp, got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s: expected %h seen %h", what, exp, got);
        end
    endtask : check_bit
    task automatic check_byte(input string what, input logic [7:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s: expected %h seen %h", what, exp, got);
        end
    endtask : check_byte
    task automatic release_check(input logic pf);
        repeat (hold - 4) @(negedge clk_sys);
        check_bit("reset held", 1'b0, sys_reset_out);
        check_bit("primary fail held", pf, primary_fail_n);
        repeat (16) @(negedge clk_sys);
        check_bit("reset released", 1'b1, sys_reset_out);
        check_bit("primary fail off", 1'b1, primary_fail_n);
    endtask : release_check
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    initial begin
        seed = lfsr(seed);
        nv_ctrl_in = ctrl_of(seed[1:0]);
        hold = hold_of(nv_ctrl_in);
        want = nv_ctrl_in;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        check_bit("reset at power-up", 1'b0, sys_reset_out);
        @(posedge clk_sys);
        rstn <= 1'b1;
        release_check(1'b0);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            @(posedge clk_sys);
            flags_in.primary_low <= !k[0];
            manual_reset_in_n <= !k[0];
            repeat (10 + seed[3:0]) @(negedge clk_sys);
            check_bit("reset cause", 1'b0, sys_reset_out);
            @(posedge clk_sys);
            flags_in.primary_low <= 1'b0;
            manual_reset_in_n <= 1'b1;
            release_check(k[0]);
        end
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_sys);
            flags_in.second_low <= !k[0];
            repeat (10) @(negedge clk_sys);
            check_bit("second fail", k[0],
                      second_supply_fail_out_n);
        end
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            @(posedge clk_sys);
            write_protect_in <= (k == 1);
            d = (k == 0) ? ctrl_of(seed[1:0]) : want ^ 8'h81;
            if (k == 0) want = d;
            base = n_store;
            serial_host_model_i.write_ctrl((k == 2) ? 8'ha0 : 8'hb0,
                                           seed[15:8], d, acks);
            check_byte("acks", (k == 2) ? 8'h00 : 8'h07,
                       {5'h00, acks});
            repeat (20) @(negedge clk_sys);
            check_byte("store pulses", {7'h00, k == 0},
                       8'(n_store - base));
            check_byte("stored byte", want, nv_ctrl_out);
        end
        @(posedge clk_sys);
        write_protect_in <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            serial_host_model_i.restart();
            repeat (10) @(negedge clk_sys);
            check_bit("wd cleared", 1'b1, watchdog_fault_out_n);
            repeat (WD0 - 60) @(negedge clk_sys);
            check_bit("wd early", 1'b1, watchdog_fault_out_n);
            for (int t = 0; t < 100 && watchdog_fault_out_n !== 1'b0; t++)
                @(negedge clk_sys);
            check_bit("wd fault", 1'b0, watchdog_fault_out_n);
        end
        // Period code 3 turns the watchdog off
        serial_host_model_i.write_ctrl(8'hb0, 8'h00, 8'h60, acks);
        repeat (WD0 + 20) @(negedge clk_sys);
        check_bit("wd off", 1'b1, watchdog_fault_out_n);
        @(posedge clk_sys);
        flags_in <= 4'ha;
        repeat (10) @(negedge clk_sys);
        check_bit("backup select", 1'b1, switched_supply_out);
        check_bit("backup active", 1'b1, backup_active_out);
        serial_host_model_i.write_ctrl(8'hb0, 8'h00, 8'h00, acks);
        check_byte("backup acks", 8'h00, {5'h00, acks});
        @(posedge clk_sys);
        flags_in <= 4'h8;
        repeat (10) @(negedge clk_sys);
        check_bit("backup band", 1'b1, switched_supply_out);
        @(posedge clk_sys);
        flags_in <= 4'h9;
        repeat (10) @(negedge clk_sys);
        check_bit("primary select", 1'b0, switched_supply_out);
        check_bit("backup off", 1'b0, backup_active_out);
        conclude();
    end
endmodule : supply_supervisor_watchdog_bench
